// [mup_pkg.sv]
// Purpose: Shared constants and types of the management user access port
// Assumes: 32-bit register port, one word per register
// Notes: Offsets are byte addresses on the plain register port
package mup_pkg;

    // Register offsets
    localparam logic [7:0] OFS_ACCESS0 = 8'h00;
    localparam logic [7:0] OFS_MASK_SET = 8'h04;
    localparam logic [7:0] OFS_MASK_CLEAR = 8'h08;
    localparam logic [7:0] OFS_EVENT_RAW = 8'h0C;
    localparam logic [7:0] OFS_EVENT_CLEAR = 8'h10;
    localparam logic [7:0] OFS_MASKED = 8'h14;
    localparam logic [7:0] OFS_CONTROL = 8'h18;

    // Field positions
    localparam int GO_BIT = 31;
    localparam int WR_BIT = 30;
    localparam int ACK_BIT = 29;
    localparam int CTRL_EN_BIT = 0;
    localparam int NUM_CHAN = 2;

    // Values after reset
    localparam logic [31:0] ACCESS_RESET = 32'h0000_0000;
    localparam logic [1:0] MASK_RESET = 2'h0;
    localparam logic [1:0] EVENT_RESET = 2'h0;
    localparam logic CTRL_EN_RESET = 1'b0;

    // Frame bit positions, counted from the first preamble bit
    localparam logic [5:0] FRAME_LAST = 6'h3F;
    localparam logic [5:0] TA_FIRST = 6'h2E;
    localparam logic [5:0] TA_SECOND = 6'h2F;
    localparam logic [5:0] DATA_FIRST = 6'h30;

    // Bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } mup_bus_req_t;

    // Access register layout
    typedef struct packed {
        logic go;
        logic wr;
        logic ack;
        logic [2:0] rsvd;
        logic [4:0] target_reg_index;
        logic [4:0] target_phy_index;
        logic [15:0] data;
    } mup_access_t;

    // Management pin group
    typedef struct packed {
        logic mdio_out;
        logic mdio_oe;
    } mup_pin_out_t;

endpackage

// [mup_sync.sv]
// Purpose: Two-stage synchroniser for inputs from outside ref_clk
// Assumes: Each bit is an independent level
// Notes: Only the second stage is visible outside
`timescale 1ns/10ps
module mup_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    meta_q[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= d[i];
                    q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

endmodule

// [mup_user_access.sv]
// Purpose: User access port of a management data controller
// Assumes: Link clock arrives as a pin and is sampled by ref_clk
// Notes: Only channel 0 has an access register; channel 1 owns mask bits
//
// Function
// - A 1 written to mask clear bit 1 disables channel 1 completion irqs.
// - A 1 written to mask clear bit 0 disables channel 0 completion irqs.
// - Mask clear bits read 0 when enabled and 1 when disabled, upper zero.
// - A 1 written to the trigger bit queues one transaction run later.
// - The trigger cannot be set while the management machine is disabled.
// - The trigger clears itself once the transaction has fully completed.
// - While the trigger reads 1, writes to the access register are blocked.
// - The direction bit selects a PHY register write (1) or read (0).
// - The acknowledge bit is written by software and, on a read, set when the PHY acknowledges.
// - Bits 25 to 21 hold the index of the PHY register targeted.
// - Bits 20 to 16 hold the address of the PHY targeted.
// - Bits 15 to 0 hold write data, or the data returned on a read.
// - Completion of a channel 0 transaction sets its event bit, W1 clears.
// - A masked bit is set only while its event and its enable are both set.
`timescale 1ns/10ps
module mup_user_access (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Register port
    input wire mup_pkg::mup_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    // Management link pins
    input wire logic mdc_in,
    input wire logic mdio_in,
    output mup_pkg::mup_pin_out_t mdio_pins,
    // Interrupt
    output logic irq
);

    typedef enum logic [0:0] {
        MUP_IDLE,
        MUP_RUN
    } mup_state_t;

    // Frame image: preamble, start, opcode, addresses, turnaround, data
    function automatic logic [63:0] mup_frame(mup_pkg::mup_access_t a);
        logic [1:0] op;
        logic [1:0] ta;
        logic [15:0] dat;
        op = a.wr ? 2'h1 : 2'h2;
        ta = a.wr ? 2'h2 : 2'h3;
        dat = a.wr ? a.data : 16'hFFFF;
        mup_frame = {32'hFFFF_FFFF, 2'h1, op, a.target_phy_index,
                     a.target_reg_index, ta, dat};
    endfunction

    // Address decode, reused for reads and writes
    function automatic logic hit(logic [7:0] addr, logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Registers
    mup_pkg::mup_access_t access_q, access_d;
    logic [1:0] mask_q, mask_d;
    logic [1:0] event_q, event_d;
    logic ctrl_en_q;
    logic [31:0] rdata_q;
    logic irq_q;
    mup_state_t state_q, state_d;
    logic [5:0] bit_idx_q, bit_idx_d;
    logic mdo_q, mdo_d;
    logic oe_q, oe_d;
    logic mdc_prev_q;

    // Synchronised pins
    logic [1:0] pins_sync;
    logic mdc_s;
    logic mdi_s;

    mup_sync #(.W(2)) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .d({mdc_in, mdio_in}),
        .q(pins_sync)
    );

    assign mdc_s = pins_sync[1];
    assign mdi_s = pins_sync[0];

    // Link clock edges, seen two samples late through the synchroniser
    wire mdc_rise = mdc_s & ~mdc_prev_q;
    wire mdc_fall = ~mdc_s & mdc_prev_q;

    // Write decode
    wire wr_access = bus_req.wr & hit(bus_req.addr, mup_pkg::OFS_ACCESS0);
    wire wr_mset = bus_req.wr & hit(bus_req.addr, mup_pkg::OFS_MASK_SET);
    wire wr_mclr = bus_req.wr & hit(bus_req.addr, mup_pkg::OFS_MASK_CLEAR);
    wire wr_eclr = bus_req.wr & hit(bus_req.addr, mup_pkg::OFS_EVENT_CLEAR);
    wire wr_ctrl = bus_req.wr & hit(bus_req.addr, mup_pkg::OFS_CONTROL);

    // Software may only touch the access register while idle
    wire access_open = wr_access & ~access_q.go;
    wire [31:0] wd = bus_req.wdata;
    wire go_req = wd[mup_pkg::GO_BIT] & ctrl_en_q;

    // Frame progress
    wire [63:0] frame = mup_frame(access_q);
    wire start_ok = (state_q == MUP_IDLE) & access_q.go & mdc_fall;
    wire is_read = ~access_q.wr;
    wire last_rise = (state_q == MUP_RUN) & mdc_rise
                     & (bit_idx_q == mup_pkg::FRAME_LAST);
    wire ack_rise = (state_q == MUP_RUN) & mdc_rise & is_read
                    & (bit_idx_q == mup_pkg::TA_SECOND);
    wire data_rise = (state_q == MUP_RUN) & mdc_rise & is_read
                     & (bit_idx_q >= mup_pkg::DATA_FIRST);
    wire [5:0] next_idx = bit_idx_q + 6'h01;
    wire [5:0] next_pos = mup_pkg::FRAME_LAST - next_idx;

    // Channel 0 completes; channel 1 has no engine here
    wire [1:0] done_evt = {1'b0, last_rise};
    wire [1:0] masked = event_q & mask_q;

    // Read data selection
    wire [31:0] rd_access = {access_q.go, access_q.wr, access_q.ack, 3'h0,
                             access_q.target_reg_index,
                             access_q.target_phy_index, access_q.data};
    wire [31:0] rd_mask_clr = {30'h0, ~mask_q};
    wire [31:0] rd_mux =
        hit(bus_req.addr, mup_pkg::OFS_ACCESS0) ? rd_access :
        hit(bus_req.addr, mup_pkg::OFS_MASK_SET) ? {30'h0, mask_q} :
        hit(bus_req.addr, mup_pkg::OFS_MASK_CLEAR) ? rd_mask_clr :
        hit(bus_req.addr, mup_pkg::OFS_EVENT_RAW) ? {30'h0, event_q} :
        hit(bus_req.addr, mup_pkg::OFS_MASKED) ? {30'h0, masked} :
        hit(bus_req.addr, mup_pkg::OFS_CONTROL) ? {31'h0, ctrl_en_q} :
        32'h0000_0000;

    // Mask set and clear sit at different offsets, so never collide
    always_comb begin
        mask_d = mask_q;
        if (wr_mset) begin
            mask_d = mask_q | wd[1:0];
        end
        if (wr_mclr) begin
            mask_d[1] = mask_q[1] & ~wd[1];
            mask_d[0] = mask_q[0] & ~wd[0];
        end
    end

    // A completion in the clearing cycle survives the clear
    always_comb begin
        event_d = event_q;
        if (wr_eclr) begin
            event_d = event_q & ~wd[1:0];
        end
        event_d = event_d | done_evt;
    end

    // Access register: software fields, then hardware updates
    always_comb begin
        access_d = access_q;
        if (access_open) begin
            access_d.go = go_req;
            access_d.wr = wd[mup_pkg::WR_BIT];
            access_d.ack = wd[mup_pkg::ACK_BIT];
            access_d.target_reg_index = wd[25:21];
            access_d.target_phy_index = wd[20:16];
            access_d.data = wd[15:0];
        end
        if (start_ok & is_read) begin
            access_d.ack = 1'b0;
        end
        if (ack_rise) begin
            access_d.ack = ~mdi_s;
        end
        if (data_rise) begin
            access_d.data = {access_q.data[14:0], mdi_s};
        end
        if (last_rise) begin
            access_d.go = 1'b0;
        end
        access_d.rsvd = 3'h0;
    end

    // Serialiser: drive on falling edges, PHY samples on rising edges
    always_comb begin
        state_d = state_q;
        bit_idx_d = bit_idx_q;
        mdo_d = mdo_q;
        oe_d = oe_q;
        case (state_q)
            MUP_IDLE: begin
                oe_d = 1'b0;
                mdo_d = 1'b1;
                if (start_ok) begin
                    state_d = MUP_RUN;
                    bit_idx_d = 6'h00;
                    mdo_d = frame[63];
                    oe_d = 1'b1;
                end
            end
            MUP_RUN: begin
                if (last_rise) begin
                    state_d = MUP_IDLE;
                    oe_d = 1'b0;
                    mdo_d = 1'b1;
                end else if (mdc_fall) begin
                    bit_idx_d = next_idx;
                    mdo_d = frame[next_pos];
                    // On reads, release the line for the PHY from turnaround on; writes keep driving
                    oe_d = access_q.wr | (next_idx < mup_pkg::TA_FIRST);
                end
            end
            default: begin
                state_d = MUP_IDLE;
                oe_d = 1'b0;
                mdo_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            access_q <= mup_pkg::ACCESS_RESET;
            mask_q <= mup_pkg::MASK_RESET;
            event_q <= mup_pkg::EVENT_RESET;
            ctrl_en_q <= mup_pkg::CTRL_EN_RESET;
        end else begin
            access_q <= access_d;
            mask_q <= mask_d;
            event_q <= event_d;
            if (wr_ctrl) begin
                ctrl_en_q <= wd[mup_pkg::CTRL_EN_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= MUP_IDLE;
            bit_idx_q <= 6'h00;
            mdo_q <= 1'b1;
            oe_q <= 1'b0;
            mdc_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_idx_q <= bit_idx_d;
            mdo_q <= mdo_d;
            oe_q <= oe_d;
            mdc_prev_q <= mdc_s;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
            irq_q <= 1'b0;
        end else begin
            rdata_q <= bus_req.rd ? rd_mux : 32'h0000_0000;
            irq_q <= |(event_d & mask_d);
        end
    end

    assign bus_rdata = rdata_q;
    assign irq = irq_q;
    assign mdio_pins.mdio_out = mdo_q;
    assign mdio_pins.mdio_oe = oe_q;

endmodule

// [mup_user_access_assertions.sv]
// Purpose: Port checks of the management user access port
// Assumes: Mask bits change only through the register port
// Notes: Mask is mirrored here from the bus traffic
`timescale 1ns/10ps
module mup_user_access_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Register port
    input wire mup_pkg::mup_bus_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    // Link and interrupt
    input wire logic mdc_in,
    input wire logic mdio_in,
    input wire mup_pkg::mup_pin_out_t mdio_pins,
    input wire logic irq
);
    logic [1:0] mask_q;
    wire set_w = bus_req.wr && bus_req.addr == mup_pkg::OFS_MASK_SET;
    wire clr_w = bus_req.wr && bus_req.addr == mup_pkg::OFS_MASK_CLEAR;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= mup_pkg::MASK_RESET;
        end else if (set_w) begin
            mask_q <= mask_q | bus_req.wdata[1:0];
        end else if (clr_w) begin
            mask_q <= mask_q & ~bus_req.wdata[1:0];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    rd_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 0)
        else $error("read data not zero");
    clr_read_a: assert property ($past(bus_req.rd) &&
        $past(bus_req.addr) == mup_pkg::OFS_MASK_CLEAR
        |-> bus_rdata == {30'h0, ~$past(mask_q)}) else $error("mask clear read");
    set_read_a: assert property ($past(bus_req.rd) &&
        $past(bus_req.addr) == mup_pkg::OFS_MASK_SET
        |-> bus_rdata == {30'h0, $past(mask_q)}) else $error("mask set read");
    unmapped_a: assert property ($past(bus_req.rd) &&
        $past(bus_req.addr) > mup_pkg::OFS_CONTROL |-> bus_rdata == 0)
        else $error("unmapped read");
    rsvd_zero_a: assert property ($past(bus_req.rd) &&
        $past(bus_req.addr) == mup_pkg::OFS_ACCESS0 |-> bus_rdata[28:26] == 0)
        else $error("reserved bits set");
    pre_start_a: assert property ($rose(mdio_pins.mdio_oe)
        |-> mdio_pins.mdio_out) else $error("frame not started by one");
    fall_start_a: assert property ($rose(mdio_pins.mdio_oe)
        |-> !$past(mdc_in, 2)) else $error("frame start off falling edge");
    bit_edge_a: assert property (mdio_pins.mdio_oe &&
        $past(mdio_pins.mdio_oe) && $changed(mdio_pins.mdio_out)
        |-> !$past(mdc_in, 2)) else $error("bit changed off falling edge");
    irq_fall_a: assert property ($fell(irq) |-> $past(bus_req.wr) ||
        $past(bus_req.wr, 2) || $past(bus_req.wr, 3))
        else $error("irq dropped without a write");
endmodule
bind mup_user_access mup_user_access_checker u_chk (.ref_clk(ref_clk),
    .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata), .mdc_in(mdc_in),
    .mdio_in(mdio_in), .mdio_pins(mdio_pins), .irq(irq));

// [mup_phy_model.sv]
// Purpose: Behavioural PHY on the management line
// Assumes: Line has a pull-up; released bits read one
// Notes: Answers reads only when ack_en is high
`timescale 1ns/10ps
module mup_phy_model (
    // Link
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    output logic mdio_wire,
    // Bench control
    input wire logic ack_en,
    input wire logic [15:0] rd_val,
    output logic [63:0] frame
);
    logic [63:0] sr = '0;
    int n = 0;
    logic is_rd = 1'b0;
    logic drv = 1'b0;
    logic val = 1'b1;
    assign mdio_wire = mdio_oe ? mdio_out : (drv ? val : 1'b1);
    initial frame = '0;
    always @(posedge mdc) begin
        if (n > 0 || mdio_oe) begin
            sr = {sr[62:0], mdio_wire};
            n = (n == 63) ? 0 : n + 1;
            if (n == 36) is_rd = sr[1] & ~sr[0];
            if (n == 0) frame = sr;
        end
    end
    always @(negedge mdc) begin
        drv = is_rd && ack_en && n >= 47;
        val = (n == 47) ? 1'b0 : rd_val[63 - n];
    end
endmodule

// [mup_user_access_tb.sv]
// Purpose: Self-checking bench of the management user access port
// Assumes: Free running link clock of 48 ns
// Notes: Reads are checked by a monitor from a queue
`timescale 1ns/10ps
module mup_user_access_tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic mdc = 1'b1;
    mup_pkg::mup_bus_req_t bus_req = '0;
    logic [31:0] bus_rdata;
    logic mdio_wire;
    mup_pkg::mup_pin_out_t mdio_pins;
    logic irq;
    logic ack_en = 1'b1;
    logic [15:0] rd_val = 16'h0;
    logic [63:0] frame;
    logic p1 = 1'b0;
    logic [31:0] expq[$];
    int errors = 0;
    int n_compared = 0;
    logic [4:0] phy;
    logic [4:0] rg;
    logic [15:0] dat;
    logic [15:0] got;
    always #2 ref_clk = ~ref_clk;
    initial #7 forever #24 mdc = ~mdc;
    mup_user_access dut (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .mdc_in(mdc), .mdio_in(mdio_wire),
        .mdio_pins(mdio_pins), .irq(irq));
    mup_phy_model phy_m (.mdc(mdc), .mdio_out(mdio_pins.mdio_out),
        .mdio_oe(mdio_pins.mdio_oe), .mdio_wire(mdio_wire),
        .ack_en(ack_en), .rd_val(rd_val), .frame(frame));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Reads carry noise on wdata; d is then the expected word
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        bus_req <= '{w, ~w, a, w ? d : $urandom};
        if (!w) expq.push_back(d);
        @(posedge ref_clk);
        bus_req <= '0;
        @(posedge ref_clk);
    endtask
    task automatic run(input logic [31:0] word);
        int i;
        bus(1'b1, mup_pkg::OFS_ACCESS0, word);
        bus(1'b1, mup_pkg::OFS_ACCESS0, ~word);
        bus(1'b0, mup_pkg::OFS_ACCESS0, word);
        for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge ref_clk);
        check(64'(irq), 64'h1);
    endtask
    // Read data stands only in the cycle after the strobe: look mid-cycle
    always @(posedge ref_clk) begin
        p1 <= bus_req.rd;
    end
    always @(negedge ref_clk) begin
        if (p1) check(64'(bus_rdata), 64'(expq.pop_front()));
    end
    initial begin
        #100000;
        errors++;
        close_out();
    end
    initial begin
        void'($urandom(32'h58E3));
        phy = 5'($urandom);
        rg = 5'($urandom);
        dat = 16'($urandom);
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        bus(1'b0, mup_pkg::OFS_MASK_CLEAR, 32'h0000_0003);
        bus(1'b0, 8'h1C, 32'h0);
        // Machine still off: trigger must not stick
        bus(1'b1, mup_pkg::OFS_ACCESS0, {3'h5, 3'h0, rg, phy, dat});
        repeat (40) @(posedge ref_clk);
        check(64'(mdio_pins.mdio_oe), 64'h0);
        bus(1'b0, mup_pkg::OFS_ACCESS0, {3'h1, 3'h0, rg, phy, dat});
        bus(1'b1, mup_pkg::OFS_CONTROL, 32'h0000_0001);
        bus(1'b1, mup_pkg::OFS_MASK_SET, 32'h0000_0003);
        bus(1'b0, mup_pkg::OFS_MASK_CLEAR, 32'h0);
        run({3'h6, 3'h0, rg, phy, dat});
        check(frame, {32'hFFFF_FFFF, 4'h5, phy, rg, 2'h2, dat});
        bus(1'b0, mup_pkg::OFS_ACCESS0, {3'h2, 3'h0, rg, phy, dat});
        bus(1'b0, mup_pkg::OFS_EVENT_RAW, 32'h0000_0001);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, mup_pkg::OFS_EVENT_CLEAR, 32'h0000_0001);
            check(64'(irq), 64'h0);
            ack_en <= (k == 0);
            rd_val <= 16'($urandom);
            phy = 5'($urandom);
            rg = 5'($urandom);
            bus(1'b0, mup_pkg::OFS_EVENT_RAW, 32'h0);
            got = ack_en ? rd_val : 16'hFFFF;
            run({3'h4, 3'h0, rg, phy, dat});
            check(frame, {32'hFFFF_FFFF, 4'h6, phy, rg, 1'b1, ~ack_en,
                got});
            bus(1'b0, mup_pkg::OFS_ACCESS0, {2'h0, ack_en, 3'h0, rg, phy,
                got});
        end
        bus(1'b1, mup_pkg::OFS_MASK_CLEAR, 32'hFFFF_FFFC);
        bus(1'b0, mup_pkg::OFS_MASK_CLEAR, 32'h0);
        check(64'(irq), 64'h1);
        bus(1'b1, mup_pkg::OFS_MASK_CLEAR, 32'h0000_0001);
        bus(1'b0, mup_pkg::OFS_MASK_CLEAR, 32'h0000_0001);
        check(64'(irq), 64'h0);
        bus(1'b0, mup_pkg::OFS_MASKED, 32'h0);
        bus(1'b1, mup_pkg::OFS_MASK_CLEAR, 32'h0000_0002);
        bus(1'b0, mup_pkg::OFS_MASK_CLEAR, 32'h0000_0003);
        repeat (4) @(posedge ref_clk);
        close_out();
    end
endmodule
